// ==== ppr_analog_route.sv ====
// Registered routing of detector sense and pump current to the analog controls
`timescale 1ns/1ps
`include "ppr_regs_map.svh"
module ppr_analog_route (
  input  wire logic                 sys_clk_i,
  input  wire logic                 srst_i,
  ppr_route_if.route                ctl,
  output ppr_pkg::ppr_sense_type    sense_o,
  output ppr_pkg::ppr_pump_code_type pump_code_o,
  output ppr_pkg::ppr_tenth_ma_type pump_tenth_ma_o,
  output logic                      sense_misuse_o
);
  import ppr_pkg::*;

  // Linear in code: 0.6 mA per step, code 111 lands on 4.8 mA
  function automatic ppr_tenth_ma_type pump_tenths(input ppr_pump_code_type c);
    pump_tenths = 6'((c + 6'h01) * `PPR_PUMP_STEP_TENTH);
  endfunction : pump_tenths

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sense_o <= PPR_SENSE_POS;
    end else begin
      // Internal oscillator never sees negative sense
      sense_o <= ctl.ext_osc ? ctl.sense : PPR_SENSE_POS;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pump_code_o     <= 3'(`PPR_RST_DET_CTRL >> `PPR_PUMP_LSB);
      pump_tenth_ma_o <= `PPR_PUMP_MAX_TENTH;
    end else begin
      pump_code_o     <= ctl.pump_code;
      pump_tenth_ma_o <= pump_tenths(ctl.pump_code);
    end
  end

  // Flags a host that breaks the positive-sense expectation
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sense_misuse_o <= 1'b0;
    end else begin
      sense_misuse_o <= (ctl.sense == PPR_SENSE_NEG) && !ctl.ext_osc;
    end
  end
endmodule : ppr_analog_route

// ==== ppr_host_model.sv ====
// Host controller model that drives the register port of the tag and detector bank
`timescale 1ns/1ps
module ppr_host_model (
  input  wire logic                  sys_clk_i,
  input  wire ppr_pkg::ppr_byte_type rdata_i,
  input  wire logic                  rd_valid_i,
  output ppr_pkg::ppr_addr_type      addr_o,
  output logic                       wr_o,
  output ppr_pkg::ppr_byte_type      wdata_o,
  output logic                       rd_o
);
  import ppr_pkg::*;
  initial begin
    addr_o = 10'h3FF;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end
  // Idle address and data are inverted so stale values never look valid
  task automatic wr(input ppr_addr_type a, input ppr_byte_type d);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input ppr_addr_type a, output ppr_byte_type d, output logic v);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    v = rd_valid_i;
    d = rdata_i;
  endtask : rd
endmodule : ppr_host_model

// ==== ppr_pkg.sv ====
// Types shared by the detector and version tag register block
package ppr_pkg;
  typedef logic [7:0]              ppr_byte_type;
  typedef logic [9:0]              ppr_addr_type;
  typedef logic [2:0]              ppr_pump_code_type;
  typedef logic [5:0]              ppr_tenth_ma_type;
  typedef enum logic {
    PPR_SENSE_POS = 1'b0,
    PPR_SENSE_NEG = 1'b1
  } ppr_sense_type;
endpackage : ppr_pkg

// ==== ppr_regs.sv ====
// Register bank: user version tag and detector/pump control byte
`timescale 1ns/1ps
`include "ppr_regs_map.svh"
module ppr_regs (
  input  wire logic                  sys_clk_i,
  input  wire logic                  srst_i,
  input  wire ppr_pkg::ppr_addr_type reg_addr_i,
  input  wire logic                  reg_wr_i,
  input  wire ppr_pkg::ppr_byte_type reg_wdata_i,
  input  wire logic                  reg_rd_i,
  input  wire logic                  ext_osc_i,
  output ppr_pkg::ppr_byte_type      reg_rdata_o,
  output logic                       reg_rd_valid_o,
  output logic [15:0]                user_version_tag_o,
  output ppr_pkg::ppr_sense_type     phase_detector_sense_o,
  output ppr_pkg::ppr_pump_code_type pump_current_select_o,
  output ppr_pkg::ppr_tenth_ma_type  pump_tenth_ma_o,
  output logic                       sense_misuse_o
);
  import ppr_pkg::*;

  ppr_byte_type tag_low_q;
  ppr_byte_type tag_high_q;
  ppr_byte_type det_ctrl_q;
  ppr_byte_type rdata_d;

  ppr_route_if route_if ();

  // ****************************************************************************
  // Decode
  // ****************************************************************************
  function automatic logic hit(input ppr_addr_type a, input ppr_addr_type ofs);
    hit = (a == ofs);
  endfunction : hit

  // ****************************************************************************
  // Storage
  // ****************************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tag_low_q <= `PPR_RST_TAG_LOW;
    end else if (reg_wr_i && hit(reg_addr_i, `PPR_OFS_TAG_LOW)) begin
      tag_low_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tag_high_q <= `PPR_RST_TAG_HIGH;
    end else if (reg_wr_i && hit(reg_addr_i, `PPR_OFS_TAG_HIGH)) begin
      tag_high_q <= reg_wdata_i;
    end
  end

  // Low nibble (pump mode, power-down) is kept for readback only here
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      det_ctrl_q <= `PPR_RST_DET_CTRL;
    end else if (reg_wr_i && hit(reg_addr_i, `PPR_OFS_DET_CTRL)) begin
      det_ctrl_q <= reg_wdata_i;
    end
  end

  // Tag leaves the bank as a registered copy and via readback; no analog control reads it
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      user_version_tag_o <= {`PPR_RST_TAG_HIGH, `PPR_RST_TAG_LOW};
    end else begin
      user_version_tag_o <= {tag_high_q, tag_low_q};
    end
  end

  // ****************************************************************************
  // Readback
  // ****************************************************************************
  always_comb begin
    rdata_d = `PPR_RD_UNMAPPED;
    if (hit(reg_addr_i, `PPR_OFS_TAG_LOW)) begin
      rdata_d = tag_low_q;
    end else if (hit(reg_addr_i, `PPR_OFS_TAG_HIGH)) begin
      rdata_d = tag_high_q;
    end else if (hit(reg_addr_i, `PPR_OFS_DET_CTRL)) begin
      rdata_d = det_ctrl_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o    <= `PPR_RD_UNMAPPED;
      reg_rd_valid_o <= 1'b0;
    end else begin
      reg_rd_valid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

  // ****************************************************************************
  // Analog routing
  // ****************************************************************************
  assign route_if.sense     = ppr_sense_type'(det_ctrl_q[`PPR_BIT_SENSE]);
  assign route_if.pump_code = det_ctrl_q[`PPR_PUMP_MSB:`PPR_PUMP_LSB];
  assign route_if.ext_osc   = ext_osc_i;

  ppr_analog_route u_route (
    .sys_clk_i       (sys_clk_i),
    .srst_i          (srst_i),
    .ctl             (route_if.route),
    .sense_o         (phase_detector_sense_o),
    .pump_code_o     (pump_current_select_o),
    .pump_tenth_ma_o (pump_tenth_ma_o),
    .sense_misuse_o  (sense_misuse_o)
  );

  // ****************************************************************************
  // Assertions
  // ****************************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_tag_low_write: assert property (
    reg_wr_i && reg_addr_i == `PPR_OFS_TAG_LOW |=> tag_low_q == $past(reg_wdata_i))
    else $error("tag low byte not written");

  a_tag_high_write: assert property (
    reg_wr_i && reg_addr_i == `PPR_OFS_TAG_HIGH |=> tag_high_q == $past(reg_wdata_i))
    else $error("tag high byte not written");

  a_tag_reset_zero: assert property (
    $fell(srst_i) |-> user_version_tag_o == 16'h0000)
    else $error("tag not zero after reset");

  // Sense may still follow an oscillator switch inside the same window
  a_tag_no_effect: assert property (
    reg_wr_i && reg_addr_i != `PPR_OFS_DET_CTRL ##1 !reg_wr_i ##1 1'b1
      |-> $stable(pump_tenth_ma_o)
          && ($past(ext_osc_i) != $past(ext_osc_i, 2) || $stable(phase_detector_sense_o)))
    else $error("tag write changed analog controls");

  a_tag_output_copy: assert property (
    ##1 user_version_tag_o == {$past(tag_high_q), $past(tag_low_q)})
    else $error("tag output not tracking storage");

  a_sense_follows: assert property (
    reg_wr_i && reg_addr_i == `PPR_OFS_DET_CTRL && ext_osc_i ##1 ext_osc_i
      |=> phase_detector_sense_o == ppr_sense_type'($past(reg_wdata_i[`PPR_BIT_SENSE], 2)))
    else $error("detector sense not applied");

  a_internal_positive: assert property (
    !ext_osc_i |=> phase_detector_sense_o == PPR_SENSE_POS)
    else $error("negative sense on internal oscillator");

  a_misuse_flag: assert property (
    det_ctrl_q[`PPR_BIT_SENSE] && !ext_osc_i |=> sense_misuse_o)
    else $error("misuse flag missing");

  a_pump_code: assert property (
    reg_wr_i && reg_addr_i == `PPR_OFS_DET_CTRL
      |=> ##1 pump_current_select_o == $past(reg_wdata_i[`PPR_PUMP_MSB:`PPR_PUMP_LSB], 2))
    else $error("pump code not routed");

  a_pump_linear: assert property (
    ##1 pump_tenth_ma_o == 6'(({3'h0, $past(det_ctrl_q[`PPR_PUMP_MSB:`PPR_PUMP_LSB])} + 6'h01) * `PPR_PUMP_STEP_TENTH))
    else $error("pump current not linear");

  a_read_latency: assert property (
    reg_rd_i |=> reg_rd_valid_o && reg_rdata_o == $past(rdata_d))
    else $error("read answer wrong");

  a_unmapped_zero: assert property (
    reg_rd_i && reg_addr_i != `PPR_OFS_TAG_LOW && reg_addr_i != `PPR_OFS_TAG_HIGH
      && reg_addr_i != `PPR_OFS_DET_CTRL |=> reg_rdata_o == `PPR_RD_UNMAPPED)
    else $error("unmapped read not zero");

  // ****************************************************************************
  // Holds, readback and reset values
  // ****************************************************************************
  a_tag_low_hold: assert property (
    !(reg_wr_i && reg_addr_i == `PPR_OFS_TAG_LOW) |=> $stable(tag_low_q))
    else $error("tag low byte changed without write");

  a_tag_high_hold: assert property (
    !(reg_wr_i && reg_addr_i == `PPR_OFS_TAG_HIGH) |=> $stable(tag_high_q))
    else $error("tag high byte changed without write");

  a_ctrl_hold: assert property (
    !(reg_wr_i && reg_addr_i == `PPR_OFS_DET_CTRL) |=> $stable(det_ctrl_q))
    else $error("control byte changed without write");

  a_tag_low_read: assert property (
    reg_rd_i && reg_addr_i == `PPR_OFS_TAG_LOW |=> reg_rdata_o == $past(tag_low_q))
    else $error("tag low byte read wrong");

  a_tag_high_read: assert property (
    reg_rd_i && reg_addr_i == `PPR_OFS_TAG_HIGH |=> reg_rdata_o == $past(tag_high_q))
    else $error("tag high byte read wrong");

  a_ctrl_read: assert property (
    reg_rd_i && reg_addr_i == `PPR_OFS_DET_CTRL |=> reg_rdata_o == $past(det_ctrl_q))
    else $error("control byte read wrong");

  a_valid_one_cycle: assert property (
    !reg_rd_i |=> !reg_rd_valid_o)
    else $error("read valid without read");

  a_rdata_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");

  a_sense_reset_pos: assert property (
    $fell(srst_i) |-> phase_detector_sense_o == PPR_SENSE_POS)
    else $error("detector sense not positive after reset");

  a_pump_reset_top: assert property (
    $fell(srst_i) |-> pump_tenth_ma_o == `PPR_PUMP_MAX_TENTH)
    else $error("pump current not at top step after reset");

  a_misuse_clear: assert property (
    !det_ctrl_q[`PPR_BIT_SENSE] || ext_osc_i |=> !sense_misuse_o)
    else $error("misuse flag without misuse");

  c_tag_written:   cover property (reg_wr_i && reg_addr_i == `PPR_OFS_TAG_HIGH ##1 reg_rd_i);
  c_negative_ext:  cover property (ext_osc_i && phase_detector_sense_o == PPR_SENSE_NEG);
  c_misuse:        cover property (sense_misuse_o);
  c_pump_top_code: cover property (pump_current_select_o == 3'h7);
  c_tag_read_back: cover property (reg_rd_valid_o && reg_rdata_o != `PPR_RD_UNMAPPED);
endmodule : ppr_regs

// ==== ppr_regs_map.svh ====
// Register map and field constants for the detector and version tag registers
// ****************************************************************************
// Functional notes
// - Tag low byte register, reset zero, writable.
// - Tag high byte register, reset zero.
// - Version tag is storage only, no effect.
// - Control bit 7 selects detector sense.
// - Negative sense applies to external oscillator only.
// - Pump field bits 6:4 select linear current.
// ****************************************************************************
`ifndef PPR_REGS_MAP_SVH
`define PPR_REGS_MAP_SVH

`define PPR_ADDR_W          10
`define PPR_OFS_TAG_LOW     10'h005
`define PPR_OFS_TAG_HIGH    10'h006
`define PPR_OFS_DET_CTRL    10'h010
`define PPR_RST_TAG_LOW     8'h00
`define PPR_RST_TAG_HIGH    8'h00
`define PPR_RST_DET_CTRL    8'h7D
`define PPR_RD_UNMAPPED     8'h00
`define PPR_BIT_SENSE       7
`define PPR_PUMP_MSB        6
`define PPR_PUMP_LSB        4
`define PPR_PUMP_STEP_TENTH 6'h06
`define PPR_PUMP_MAX_TENTH  6'h30

`endif

// ==== ppr_regs_tb_top.sv ====
// Self-checking bench for the tag and detector control register bank
`timescale 1ns/1ps
module ppr_regs_tb_top;
  import ppr_pkg::*;
  logic              sys_clk_i;
  logic              srst_i;
  logic              ext_osc;
  ppr_addr_type      addr;
  logic              wr;
  ppr_byte_type      wdata;
  logic              rd;
  ppr_byte_type      rdata;
  logic              rd_valid;
  logic [15:0]       tag;
  ppr_sense_type     sense;
  ppr_pump_code_type pump;
  ppr_tenth_ma_type  tenth;
  logic              misuse;
  int                n_fail;
  int                checks_done;

  ppr_regs i_ppr_regs (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .ext_osc_i(ext_osc), .reg_rdata_o(rdata), .reg_rd_valid_o(rd_valid),
    .user_version_tag_o(tag), .phase_detector_sense_o(sense), .pump_current_select_o(pump),
    .pump_tenth_ma_o(tenth), .sense_misuse_o(misuse));
  ppr_host_model i_ppr_host_model (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .rd_valid_i(rd_valid),
    .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input ppr_addr_type a, input ppr_byte_type e);
    ppr_byte_type d;
    logic         v;
    i_ppr_host_model.rd(a, d, v);
    chk("rd_valid", 16'h0001, 16'(v));
    chk("rdata", 16'(e), 16'(d));
  endtask : rchk
  // Analog and tag outputs trail the write edge by two cycles
  task automatic settle;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : settle
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  initial begin
    #20000;
    n_fail++;
    finish_test;
  end

  initial begin
    n_fail = 0;
    checks_done = 0;
    srst_i = 1'b1;
    ext_osc = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rchk(10'h005, 8'h00);
    rchk(10'h006, 8'h00);
    rchk(10'h010, 8'h7D);
    chk("pump", 16'h0007, 16'(pump));
    i_ppr_host_model.wr(10'h005, 8'hA5);
    i_ppr_host_model.wr(10'h006, 8'h3C);
    settle;
    chk("tag", 16'h3CA5, tag);
    chk("tenth", 16'h0030, 16'(tenth));
    chk("sense", 16'h0000, 16'(sense));
    rchk(10'h006, 8'h3C);
    i_ppr_host_model.wr(10'h007, 8'hFF);
    rchk(10'h007, 8'h00);
    for (int c = 0; c < 8; c++) begin
      i_ppr_host_model.wr(10'h010, {1'b1, c[2:0], 4'hD});
      settle;
      chk("pump", 16'(c), 16'(pump));
      chk("tenth", 16'((c + 1) * 6), 16'(tenth));
      chk("sense", 16'h0001, 16'(sense));
      rchk(10'h010, {1'b1, c[2:0], 4'hD});
    end
    // Host deliberately leaves negative sense set on the internal oscillator
    @(posedge sys_clk_i);
    ext_osc <= 1'b0;
    settle;
    chk("sense", 16'h0000, 16'(sense));
    chk("misuse", 16'h0001, 16'(misuse));
    i_ppr_host_model.wr(10'h010, 8'h7D);
    settle;
    chk("misuse", 16'h0000, 16'(misuse));
    chk("tag", 16'h3CA5, tag);
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    settle;
    chk("tag", 16'h0000, tag);
    rchk(10'h005, 8'h00);
    finish_test;
  end
endmodule : ppr_regs_tb_top

// ==== ppr_route_if.sv ====
// Control fields carried from the register bank to the analog routing stage
`timescale 1ns/1ps
interface ppr_route_if;
  import ppr_pkg::*;
  ppr_sense_type      sense;
  ppr_pump_code_type  pump_code;
  logic               ext_osc;
  modport bank  (output sense, output pump_code, output ext_osc);
  modport route (input sense, input pump_code, input ext_osc);
endinterface : ppr_route_if
